//--- dar_access_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "dar_consts.svh"
module dar_access_regs (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                linkEnabled,
  input  wire dar_pkg::dar_addr_t  regAddr,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire dar_pkg::dar_byte_t  regWrData,
  output var  dar_pkg::dar_byte_t  regRdData,
  output var  logic                regRdValid,
  input  wire logic                keyUrowGranted,
  input  wire logic                keyNvmGranted,
  input  wire logic                keyEraseGranted,
  input  wire logic                nvmProgDone,
  input  wire logic                chipEraseDone,
  input  wire logic                linkOpActive,
  input  wire logic                contentionSeen,
  input  wire logic                systemInReset,
  input  wire logic                systemInSleep,
  input  wire logic                nvmProgReady,
  input  wire logic                userRowProgReady,
  input  wire logic                lockBitsSet,
  input  wire logic [2:0]          crcStatusIn,
  output var  logic                phyShutdown,
  output var  logic                nackReply,
  output var  logic                contentionError,
  output var  logic [1:0]          linkClockSelect,
  output var  logic                systemResetRequest,
  output var  logic                systemClockRequest,
  output var  logic                userRowDone
);
  import dar_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic darHit(input dar_addr_t a, input dar_addr_t o);
    darHit = (a == o);
  endfunction

  // Reserved CRC codes are never reported, the field reads as idle
  function automatic logic [2:0] darCrcFilter(input logic [2:0] v);
    case (v)
      `DAR_CRC_OFF,
      `DAR_CRC_BUSY,
      `DAR_CRC_OK,
      `DAR_CRC_FAIL: darCrcFilter = v;
      default:       darCrcFilter = `DAR_CRC_OFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  dar_link_e linkState_reg;
  dar_link_e linkState_next;
  logic      blockRst;
  logic      enterOn;
  logic      wrLinkB;
  logic      wrKey;
  logic      wrRstReq;
  logic      wrClkCtl;
  logic      wrSysCtl;
  logic      rdSysStat;
  logic      linkDisWr;

  assign blockRst = rst | (linkState_reg != LINK_ON);
  assign enterOn  = (linkState_reg == LINK_OFF) & linkEnabled;

  // Only link-instruction accesses reach this port; no CPU path exists
  assign wrLinkB   = regWrEn & ~blockRst
                   & darHit(regAddr, `DAR_OFF_LINKB); // R21
  assign wrKey     = regWrEn & ~blockRst & darHit(regAddr, `DAR_OFF_KEY);
  assign wrRstReq  = regWrEn & ~blockRst & darHit(regAddr, `DAR_OFF_SYSRST);
  assign wrClkCtl  = regWrEn & ~blockRst & darHit(regAddr, `DAR_OFF_CLKCTL);
  assign wrSysCtl  = regWrEn & ~blockRst & darHit(regAddr, `DAR_OFF_SYSCTL);
  assign rdSysStat = regRdEn & ~blockRst & darHit(regAddr, `DAR_OFF_SYSSTAT);
  assign linkDisWr = wrLinkB & regWrData[`DAR_BIT_LINKDIS];

  // After a disable the link waits for its enable to drop before rising
  always_comb begin
    linkState_next = linkState_reg;
    case (linkState_reg)
      LINK_OFF: begin
        if (linkEnabled) begin
          linkState_next = LINK_ON;
        end
      end
      LINK_ON: begin
        if (!linkEnabled) begin
          linkState_next = LINK_OFF;
        end else if (linkDisWr) begin
          linkState_next = LINK_WAIT; // R3
        end
      end
      LINK_WAIT: begin
        if (!linkEnabled) begin
          linkState_next = LINK_OFF;
        end
      end
      default: linkState_next = LINK_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      linkState_reg <= LINK_OFF;
    end else begin
      linkState_reg <= linkState_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phyShutdown <= 1'b0;
    end else begin
      phyShutdown <= linkDisWr; // R3
    end
  end

  // ----------------------------------------------------------------
  // Link control B
  // ----------------------------------------------------------------
  logic nack_reply_disable_reg;
  logic ccDis_reg;

  always_ff @(posedge clk) begin
    if (blockRst) begin
      nack_reply_disable_reg <= 1'b0;
      ccDis_reg   <= 1'b0;
    end else if (wrLinkB) begin
      nack_reply_disable_reg <= regWrData[`DAR_BIT_NACKOFF];
      ccDis_reg   <= regWrData[`DAR_BIT_CCDIS];
    end
  end

  // A system reset that starts mid-operation answers with NACK unless off
  logic sysRstPrev_reg;
  logic sysRstRise;
  assign sysRstRise = systemInReset & ~sysRstPrev_reg;

  always_ff @(posedge clk) begin
    if (blockRst) begin
      sysRstPrev_reg  <= 1'b0;
      nackReply       <= 1'b0;
      contentionError <= 1'b0;
    end else begin
      sysRstPrev_reg  <= systemInReset;
      nackReply       <= sysRstRise & linkOpActive & ~nack_reply_disable_reg; // R1
      contentionError <= contentionSeen & ~ccDis_reg;              // R2
    end
  end

  // ----------------------------------------------------------------
  // Keys
  // ----------------------------------------------------------------
  logic userRowKey;
  logic nvmKey;
  logic eraseKey;
  logic urowClearWr;

  assign urowClearWr = wrKey & ~regWrData[`DAR_BIT_KEY_UROW];

  dar_key_status u_keys (
    .clk             (clk),
    .blockRst        (blockRst), // R3
    .keyUrowGranted  (keyUrowGranted & ~blockRst),
    .keyNvmGranted   (keyNvmGranted & ~blockRst),
    .keyEraseGranted (keyEraseGranted & ~blockRst),
    .nvmProgDone     (nvmProgDone),
    .chipEraseDone   (chipEraseDone),
    .urowClearWr     (urowClearWr),
    .userRowKey      (userRowKey),
    .nvmKey          (nvmKey),
    .eraseKey        (eraseKey)
  );

  // ----------------------------------------------------------------
  // System reset request and clock select
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (blockRst) begin
      systemResetRequest <= 1'b0;
    end else if (wrRstReq) begin
      systemResetRequest <= (regWrData == `DAR_RESET_SIG); // R7
    end
  end

  // Reserved select code is dropped so the link never loses its clock
  always_ff @(posedge clk) begin
    if (blockRst) begin
      linkClockSelect <= `DAR_CLKSEL_4M; // R9
    end else if (wrClkCtl && regWrData[1:0] != `DAR_CLKSEL_RSVD) begin
      linkClockSelect <= regWrData[1:0]; // R9
    end
  end

  // ----------------------------------------------------------------
  // System control
  // ----------------------------------------------------------------
  logic system_clock_request_next;
  logic urDone_next;

  always_comb begin
    system_clock_request_next = systemClockRequest;
    if (enterOn) begin
      system_clock_request_next = 1'b1; // R14
    end else if (blockRst) begin
      system_clock_request_next = 1'b0; // R14
    end else if (wrSysCtl) begin
      system_clock_request_next = regWrData[`DAR_BIT_SYSCLK]; // R13
    end
  end

  // The done strobe starts flash programming of the user row from RAM
  assign urDone_next = wrSysCtl & userRowKey
                     & regWrData[`DAR_BIT_URDONE]; // R12

  always_ff @(posedge clk) begin
    if (rst) begin
      systemClockRequest <= 1'b0;
    end else begin
      systemClockRequest <= system_clock_request_next;
    end
  end

  always_ff @(posedge clk) begin
    if (blockRst) begin
      userRowDone <= 1'b0;
    end else begin
      userRowDone <= urDone_next; // R11
    end
  end

  // ----------------------------------------------------------------
  // System status
  // ----------------------------------------------------------------
  logic       system_reset_active_reg;
  logic       system_reset_active_next;
  logic       lock_reg;
  logic [2:0] crc_reg;

  // A reset seen in the cycle of the clearing read still sets the flag
  assign system_reset_active_next = systemInReset | systemResetRequest
                     | (system_reset_active_reg & ~rdSysStat); // R15

  always_ff @(posedge clk) begin
    if (blockRst) begin
      system_reset_active_reg <= 1'b0;
      lock_reg   <= `DAR_LOCK_RESET; // R19
      crc_reg    <= `DAR_CRC_OFF;
    end else begin
      system_reset_active_reg <= system_reset_active_next;
      lock_reg   <= lockBitsSet;     // R19
      crc_reg    <= darCrcFilter(crcStatusIn); // R20
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  dar_byte_t rdLinkB;
  dar_byte_t rdKey;
  dar_byte_t rdRstReq;
  dar_byte_t rdClkCtl;
  dar_byte_t rdSysCtl;
  dar_byte_t rdSysStatV;
  dar_byte_t rdCrc;
  dar_byte_t rdMux;

  assign rdLinkB    = {3'h0, nack_reply_disable_reg, ccDis_reg, 3'h0}; // R22
  assign rdKey      = {2'h0, userRowKey, nvmKey, eraseKey, 3'h0}; // R4
  assign rdRstReq   = {7'h00, systemResetRequest}; // R8
  assign rdClkCtl   = {6'h00, linkClockSelect};
  assign rdSysCtl   = {6'h00, 1'b0, systemClockRequest};
  assign rdSysStatV = {2'h0, system_reset_active_reg, systemInSleep, nvmProgReady,
                       userRowProgReady, 1'b0, lock_reg}; // R16
  assign rdCrc      = {5'h00, crc_reg};

  always_comb begin
    case (regAddr)
      `DAR_OFF_LINKB:   rdMux = rdLinkB;
      `DAR_OFF_KEY:     rdMux = rdKey;
      `DAR_OFF_SYSRST:  rdMux = rdRstReq;
      `DAR_OFF_CLKCTL:  rdMux = rdClkCtl;
      `DAR_OFF_SYSCTL:  rdMux = rdSysCtl;
      `DAR_OFF_SYSSTAT: rdMux = rdSysStatV; // R17
      `DAR_OFF_CRC:     rdMux = rdCrc;
      default:          rdMux = 8'h00; // R22
    endcase
  end

  always_ff @(posedge clk) begin
    if (blockRst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux; // R18
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RST_SIG: assert property (@(posedge clk) disable iff (blockRst) // R7
    wrRstReq && regWrData == `DAR_RESET_SIG |=> systemResetRequest)
    else $error("Reset signature did not assert system reset");

  AST_RST_OTHER: assert property (@(posedge clk) disable iff (blockRst) // R7
    wrRstReq && regWrData != `DAR_RESET_SIG |=> !systemResetRequest)
    else $error("Other value did not release system reset");

  AST_RST_READ: assert property (@(posedge clk) disable iff (blockRst) // R8
    regRdEn && darHit(regAddr, `DAR_OFF_SYSRST) && !wrRstReq
    |=> regRdValid && regRdData == {7'h00, $past(systemResetRequest)})
    else $error("Reset request readback wrong");

  AST_CLKSEL_DEF: assert property (@(posedge clk) disable iff (rst) // R9
    enterOn |=> linkClockSelect == `DAR_CLKSEL_4M && systemClockRequest)
    else $error("Enable did not give default clock and clock request");

  AST_DISABLE: assert property (@(posedge clk) disable iff (rst) // R3
    linkDisWr && !blockRst
    |=> phyShutdown ##1 !systemClockRequest && !userRowKey && !nvmKey)
    else $error("Link disable did not reset the block");

  AST_URD_LOCKED: assert property (@(posedge clk) disable iff (blockRst) // R12
    wrSysCtl && !userRowKey |=> !userRowDone)
    else $error("User-row done accepted without key");

  AST_URD_OK: assert property (@(posedge clk) disable iff (blockRst) // R11
    wrSysCtl && userRowKey && regWrData[`DAR_BIT_URDONE]
    |=> userRowDone ##1 (!userRowDone || $past(wrSysCtl)))
    else $error("User-row done strobe wrong");

  AST_SYSTEM_CLOCK_REQUEST_WR: assert property (@(posedge clk) disable iff (blockRst) // R13
    wrSysCtl |=> systemClockRequest == $past(regWrData[`DAR_BIT_SYSCLK]))
    else $error("Clock request write not taken");

  AST_SYSTEM_RESET_ACTIVE_CLR: assert property (@(posedge clk) disable iff (blockRst) // R15
    rdSysStat && !systemInReset && !systemResetRequest |=> !system_reset_active_reg)
    else $error("Reset-active flag not cleared by read");

  AST_SYSTEM_RESET_ACTIVE_SET: assert property (@(posedge clk) disable iff (blockRst) // R15
    systemInReset |=> system_reset_active_reg)
    else $error("Reset-active flag missed a reset");

  AST_CONTENTION: assert property (@(posedge clk) disable iff (blockRst) // R2
    ccDis_reg && !wrLinkB |=> !contentionError)
    else $error("Contention reported while disabled");

  AST_NACK: assert property (@(posedge clk) disable iff (blockRst) // R1
    nack_reply_disable_reg && !wrLinkB |=> !nackReply)
    else $error("NACK sent while disabled");

  AST_CRC_ONEHOT: assert property (@(posedge clk) disable iff (blockRst) // R20
    $onehot0(crc_reg))
    else $error("CRC status not one-hot");
endmodule
`default_nettype wire

//--- dar_consts.svh
// Operation
// R1: NACK-disable suppresses NACK on reset during operation
// R2: Contention-detect-disable bit stops contention detection
// R3: Link-disable write shuts link, drops clock, resets
// R4: Key status bits 5,4,3 show active keys
// R5: NVM key flag clears when programming done
// R6: Chip-erase key flag clears when erase done
// R7: Writing 0x59 asserts system reset; else releases
// R8: Reset request reads bit0; link unaffected
// R9: Clock select 1=16,2=8,3=4 MHz, default 4
// R10: Debugger picks faster clock only at top brown-out
// R11: User-row-done written after RAM data; starts programming
// R12: User-row-done writable only with user-row key
// R13: Clock request bit holds system clock regardless of sleep
// R14: Clock request set on enable, cleared on disable
// R15: Reset-active bit sticky while in reset, read-clears
// R16: In-sleep bit mirrors idle or deeper sleep
// R17: NVM-programming-start bit shows programming may begin
// R18: User-row-programming-start bit shows user-row programming ready
// R19: Lock bit resets to 1, clears after erase
// R20: CRC status is one-hot scan state
// R21: Registers reached only through link instructions
// R22: Reserved bits read zero, ignore writes
`ifndef DAR_CONSTS_SVH
`define DAR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DAR_OFF_LINKB      4'h3
`define DAR_OFF_KEY        4'h7
`define DAR_OFF_SYSRST     4'h8
`define DAR_OFF_CLKCTL     4'h9
`define DAR_OFF_SYSCTL     4'hA
`define DAR_OFF_SYSSTAT    4'hB
`define DAR_OFF_CRC        4'hC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DAR_BIT_NACKOFF    4
`define DAR_BIT_CCDIS      3
`define DAR_BIT_LINKDIS    2
`define DAR_BIT_KEY_UROW   5
`define DAR_BIT_KEY_NVM    4
`define DAR_BIT_KEY_ERASE  3
`define DAR_BIT_URDONE     1
`define DAR_BIT_SYSCLK     0
`define DAR_BIT_RSTACT     5
`define DAR_BIT_SLEEP      4
`define DAR_BIT_NVMSTART   3
`define DAR_BIT_UROWSTART  2
`define DAR_BIT_LOCK       0

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define DAR_RESET_SIG      8'h59
`define DAR_CLKSEL_RSVD    2'h0
`define DAR_CLKSEL_16M     2'h1
`define DAR_CLKSEL_8M      2'h2
`define DAR_CLKSEL_4M      2'h3
`define DAR_CRC_OFF        3'h0
`define DAR_CRC_BUSY       3'h1
`define DAR_CRC_OK         3'h2
`define DAR_CRC_FAIL       3'h4
`define DAR_LOCK_RESET     1'h1

`endif

//--- dar_pkg.sv
`default_nettype none
package dar_pkg;
  typedef logic [7:0] dar_byte_t;
  typedef logic [3:0] dar_addr_t;
  typedef enum logic [1:0] {
    LINK_OFF,
    LINK_ON,
    LINK_WAIT
  } dar_link_e;
endpackage
`default_nettype wire

//--- dar_key_status.sv
`timescale 1ns/1ns
`default_nettype none
module dar_key_status (
  input  wire logic clk,
  input  wire logic blockRst,
  input  wire logic keyUrowGranted,
  input  wire logic keyNvmGranted,
  input  wire logic keyEraseGranted,
  input  wire logic nvmProgDone,
  input  wire logic chipEraseDone,
  input  wire logic urowClearWr,
  output var  logic userRowKey,
  output var  logic nvmKey,
  output var  logic eraseKey
);
  logic userRowKey_next;
  logic nvmKey_next;
  logic eraseKey_next;

  // ----------------------------------------------------------------
  // Key flags; a grant in the same cycle as a clear wins
  // ----------------------------------------------------------------
  assign userRowKey_next = keyUrowGranted | (userRowKey & ~urowClearWr);
  assign nvmKey_next     = keyNvmGranted | (nvmKey & ~nvmProgDone);   // R5
  assign eraseKey_next   = keyEraseGranted | (eraseKey & ~chipEraseDone); // R6

  always_ff @(posedge clk) begin
    if (blockRst) begin
      userRowKey <= 1'b0;
      nvmKey     <= 1'b0;
      eraseKey   <= 1'b0;
    end else begin
      userRowKey <= userRowKey_next; // R4
      nvmKey     <= nvmKey_next;     // R4
      eraseKey   <= eraseKey_next;   // R4
    end
  end

  AST_NVM_CLEAR: assert property (@(posedge clk) disable iff (blockRst) // R5
    nvmProgDone && !keyNvmGranted |=> !nvmKey)
    else $error("NVM key flag not cleared after programming");

  AST_ERASE_CLEAR: assert property (@(posedge clk) disable iff (blockRst) // R6
    chipEraseDone && !keyEraseGranted |=> !eraseKey)
    else $error("Erase key flag not cleared after erase");

  AST_KEY_SET: assert property (@(posedge clk) disable iff (blockRst) // R4
    keyUrowGranted |=> userRowKey)
    else $error("User-row key flag not set on grant");
endmodule
`default_nettype wire

//--- dar_debugger_model.sv
`timescale 1ns/1ns
`default_nettype none
module dar_debugger_model (
  input  wire logic               clk,
  output var  dar_pkg::dar_addr_t regAddr,
  output var  logic               regWrEn,
  output var  logic               regRdEn,
  output var  dar_pkg::dar_byte_t regWrData
);
  import dar_pkg::*;
  // ------------------------------------------------------------
  // Link instruction issue
  // ------------------------------------------------------------
  initial begin
    regAddr = 4'hF;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 8'hA5;
  end
  // Idle lines take the inverse so no stale value looks valid
  task automatic acc(input logic wr, input dar_addr_t a,
                     input dar_byte_t d);
    @(posedge clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = wr;
    regRdEn = !wr;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
endmodule
`default_nettype wire

//--- dar_access_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dar_consts.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dar_access_regs_tb;
  import dar_pkg::*;
  logic      clk = 0, rst = 1, linkEnabled = 0;
  logic      keyUrowGranted, keyNvmGranted, keyEraseGranted;
  logic      nvmProgDone, chipEraseDone, linkOpActive;
  logic      contentionSeen, systemInReset, systemInSleep;
  logic      nvmProgReady, userRowProgReady, lockBitsSet;
  logic      regWrEn, regRdEn, regRdValid, phyShutdown, nackReply;
  logic      contentionError, systemResetRequest;
  logic      systemClockRequest, userRowDone, seen;
  logic [2:0] crcStatusIn;
  logic [1:0] linkClockSelect;
  dar_addr_t regAddr;
  dar_byte_t regWrData, regRdData, ex, v;
  dar_byte_t expQ[$];
  int        failures = 0, tests_run = 0, cycles = 0;

  dar_debugger_model dbg (.clk, .regAddr, .regWrEn, .regRdEn,
                          .regWrData);
  dar_access_regs DUT (.clk, .rst, .linkEnabled, .regAddr, .regWrEn,
    .regRdEn, .regWrData, .regRdData, .regRdValid, .keyUrowGranted,
    .keyNvmGranted, .keyEraseGranted, .nvmProgDone, .chipEraseDone,
    .linkOpActive, .contentionSeen, .systemInReset, .systemInSleep,
    .nvmProgReady, .userRowProgReady, .lockBitsSet, .crcStatusIn,
    .phyShutdown, .nackReply, .contentionError, .linkClockSelect,
    .systemResetRequest, .systemClockRequest, .userRowDone);

  always #5 clk = ~clk;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input dar_addr_t a, input dar_byte_t d);
    dbg.acc(1'b1, a, d);
  endtask
  task automatic rd(input dar_addr_t a, input dar_byte_t e);
    expQ.push_back(e);
    dbg.acc(1'b0, a, 8'h00);
  endtask
  task automatic pulse_keys;
    keyUrowGranted = 1;
    keyNvmGranted = 1;
    keyEraseGranted = 1;
    tick(1);
    keyUrowGranted = 0;
    keyNvmGranted = 0;
    keyEraseGranted = 0;
    tick(1);
  endtask

  // ------------------------------------------------------------
  // Read answer monitor and hang guard
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK("regRdValid", 1'b0, regRdValid)
      end else begin
        ex = expQ.pop_front();
        `CHK("regRdData", ex, regRdData)
      end
    end
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    {keyUrowGranted, keyNvmGranted, keyEraseGranted} = 3'h0;
    {nvmProgDone, chipEraseDone, linkOpActive} = 3'h0;
    {contentionSeen, systemInReset, systemInSleep} = 3'h0;
    {nvmProgReady, userRowProgReady} = 2'h0;
    lockBitsSet = 1;
    crcStatusIn = 3'h0;
    v = 8'h00;
    void'($urandom(31));
    tick(20);
    rst = 0;
    dbg.acc(1'b0, `DAR_OFF_KEY, 8'h00);
    tick(2);
    linkEnabled = 1;
    tick(3);
    rd(`DAR_OFF_KEY, 8'h00);
    rd(`DAR_OFF_SYSRST, 8'h00);
    rd(`DAR_OFF_CLKCTL, 8'h03);
    rd(`DAR_OFF_SYSCTL, 8'h01);
    rd(`DAR_OFF_SYSSTAT, 8'h01);
    rd(`DAR_OFF_LINKB, 8'h00);
    rd(4'h5, 8'h00);
    `CHK("systemClockRequest", 1'b1, systemClockRequest)
    for (int i = 0; i < 8; i++) begin
      crcStatusIn = i[2:0];
      tick(2);
      rd(`DAR_OFF_CRC, ($countones(i) <= 1) ? 8'(i) : 8'h00);
    end
    // Faster clocks assume the brown-out level is at its top
    for (int s = 3; s >= 1; s--) begin
      v = 8'($urandom);
      wr(`DAR_OFF_CLKCTL, {v[7:2], 2'(s)});
      `CHK("linkClockSelect", 2'(s), linkClockSelect)
      rd(`DAR_OFF_CLKCTL, 8'(s));
    end
    wr(`DAR_OFF_CLKCTL, 8'h00);
    `CHK("linkClockSelect", 2'h1, linkClockSelect)
    for (int k = 0; k < 2; k++) begin
      wr(`DAR_OFF_LINKB, k ? 8'h18 : 8'h00);
      linkOpActive = 1;
      contentionSeen = 1;
      tick(1);
      systemInReset = 1;
      seen = 0;
      repeat (3) begin
        tick(1);
        if (nackReply === 1'b1) seen = 1;
      end
      `CHK("nackReply", logic'(k == 0), seen)
      `CHK("contentionError", logic'(k == 0), contentionError)
      {systemInReset, linkOpActive, contentionSeen} = 3'h0;
      tick(2);
    end
    wr(`DAR_OFF_SYSRST, `DAR_RESET_SIG);
    `CHK("systemResetRequest", 1'b1, systemResetRequest)
    systemInReset = 1;
    rd(`DAR_OFF_SYSRST, 8'h01);
    `CHK("linkClockSelect", 2'h1, linkClockSelect)
    rd(`DAR_OFF_SYSSTAT, 8'h21);
    v = 8'($urandom);
    if (v == `DAR_RESET_SIG) v = 8'h00;
    wr(`DAR_OFF_SYSRST, v);
    `CHK("systemResetRequest", 1'b0, systemResetRequest)
    systemInReset = 0;
    tick(2);
    rd(`DAR_OFF_SYSRST, 8'h00);
    rd(`DAR_OFF_SYSSTAT, 8'h21);
    rd(`DAR_OFF_SYSSTAT, 8'h01);
    {systemInSleep, nvmProgReady, userRowProgReady} = 3'h7;
    lockBitsSet = 0;
    tick(2);
    rd(`DAR_OFF_SYSSTAT, 8'h1C);
    `CHK("systemClockRequest", 1'b1, systemClockRequest)
    systemInSleep = 0;
    tick(2);
    rd(`DAR_OFF_SYSSTAT, 8'h0C);
    pulse_keys();
    rd(`DAR_OFF_KEY, 8'h38);
    nvmProgDone = 1;
    tick(1);
    nvmProgDone = 0;
    rd(`DAR_OFF_KEY, 8'h28);
    chipEraseDone = 1;
    tick(1);
    chipEraseDone = 0;
    rd(`DAR_OFF_KEY, 8'h20);
    // User-row data counts as placed in RAM before this write
    wr(`DAR_OFF_SYSCTL, 8'h03);
    `CHK("userRowDone", 1'b1, userRowDone)
    wr(`DAR_OFF_KEY, 8'h00);
    rd(`DAR_OFF_KEY, 8'h00);
    wr(`DAR_OFF_SYSCTL, 8'h02);
    `CHK("userRowDone", 1'b0, userRowDone)
    `CHK("systemClockRequest", 1'b0, systemClockRequest)
    wr(`DAR_OFF_SYSCTL, 8'h01);
    `CHK("systemClockRequest", 1'b1, systemClockRequest)
    pulse_keys();
    wr(`DAR_OFF_LINKB, 8'h04);
    `CHK("phyShutdown", 1'b1, phyShutdown)
    tick(2);
    `CHK("systemClockRequest", 1'b0, systemClockRequest)
    dbg.acc(1'b0, `DAR_OFF_KEY, 8'h00);
    tick(2);
    linkEnabled = 0;
    tick(2);
    linkEnabled = 1;
    tick(3);
    rd(`DAR_OFF_KEY, 8'h00);
    rd(`DAR_OFF_CLKCTL, 8'h03);
    rd(`DAR_OFF_SYSCTL, 8'h01);
    tick(3);
    `CHK("pendingReads", 0, expQ.size())
    give_verdict();
  end
endmodule
`default_nettype wire
